//--- logic/vism_source_map.v
// Vectored interrupt source map with AHB-Lite register access.
// Function
// - handler address is base plus vector times one fixed spacing.
// - each source has flag, enable, 3-bit priority, 2-bit subpriority; timer is 0.
// - four sources per priority word at [4:2]/[1:0] up to [28:26]/[25:24].
// - flags and enables packed 32 per word; vector 32 is bit 0 of word 1.
// - software interrupts on vectors 1,2; external pins 0-4 on vectors 3-7.
// - port change notifications on vectors 8 to 11 in port order.
// - the three general timers on vectors 17, 18 and 19.
// - comparators on vectors 23, 24 and 25.
// - combined USB interrupt on vector 29, not persistent.
// - conversion done on vector 33, after calendar alarm on 32.
// - supply level detector on vector 36, persistent.
// - logic cells on vectors 37 to 40 in cell order.
// - three SPI modules, error/transmit/receive, vectors 41 to 49, persistent.
// - first UART receive 53, transmit 54, error 55, persistent.
// - reserved vectors keep all bit positions, no source, not persistent.
//
// Decided for this implementation: the address map and register access over AHB-Lite.
`include "vism_source_map_regs.vh"
module vism_source_map #(
  parameter NVEC = 56,
  parameter NPW  = 14
) (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        core_timer_req,
  input  wire [1:0]  core_sw_req,
  input  wire [4:0]  ext_pin_req,
  input  wire [3:0]  gpio_change_req,
  input  wire [2:0]  general_timer_req,
  input  wire [2:0]  comparator_req,
  input  wire        usb_req,
  input  wire        calendar_alarm_req,
  input  wire        adc_done_req,
  input  wire        supply_level_detector_req,
  input  wire [3:0]  logic_cell_req,
  input  wire [8:0]  spi_req,
  input  wire [2:0]  uart1_req,
  output reg         irq_req_r,
  output reg  [5:0]  irq_vector_r,
  output reg  [2:0]  irq_prio_r,
  output reg  [1:0]  irq_subprio_r,
  output reg  [31:0] irq_handler_r,
  output reg         irq_out_r
);
  //////////////////////////////////////////////////////////////////////////
  // Source vector assembly.
  wire [NVEC-1:0] src;

  assign src[0]     = core_timer_req;
  assign src[2:1]   = core_sw_req;
  assign src[7:3]   = ext_pin_req;
  assign src[11:8]  = gpio_change_req;
  assign src[16:12] = 5'h00;
  assign src[19:17] = general_timer_req;
  assign src[22:20] = 3'h0;
  assign src[25:23] = comparator_req;
  assign src[28:26] = 3'h0;
  assign src[29]    = usb_req;
  assign src[31:30] = 2'h0;
  assign src[32]    = calendar_alarm_req;
  assign src[33]    = adc_done_req;
  assign src[35:34] = 2'h0;
  assign src[36]    = supply_level_detector_req;
  assign src[40:37] = logic_cell_req;
  assign src[49:41] = spi_req;
  assign src[52:50] = 3'h0;
  assign src[55:53] = uart1_req;

  //////////////////////////////////////////////////////////////////////////
  // Bus front end.
  wire       bus_take;
  reg        wr_pend_r;
  reg  [7:0] wr_addr_r;
  reg  [7:0] rd_addr_r;
  reg  [1:0] rd_stage_r;
  wire [5:0] wr_widx;
  wire       wr_hit_prio;
  wire       rd_hit_prio;

  assign bus_take    = hsel && htrans[1] && hready;
  assign wr_widx     = wr_addr_r[7:2];
  assign wr_hit_prio = (wr_addr_r >= `VISM_OFF_PRIO_FIRST) &&
                       (wr_addr_r <= `VISM_OFF_PRIO_LAST);
  assign rd_hit_prio = (rd_addr_r >= `VISM_OFF_PRIO_FIRST) &&
                       (rd_addr_r <= `VISM_OFF_PRIO_LAST);

  // The pending flag is an argument so that combinational users of this
  // decode are re-evaluated whenever it changes.
  function wr_at;
    input       pend_in;
    input [7:0] a;
    input [7:0] off;
    begin
      wr_at = pend_in && (a == off);
    end
  endfunction

  // Reads wait two cycles so that a write landing on the same edge as the
  // read's address phase is already visible in the memory output.
  always @(posedge ref_clk) begin
    if (rst) begin
      wr_pend_r  <= 1'b0;
      wr_addr_r  <= 8'h00;
      rd_addr_r  <= 8'h00;
      rd_stage_r <= 2'h0;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end else begin
      wr_pend_r <= bus_take && hwrite && (haddr[31:8] == 24'h00_0000);
      if (bus_take) begin
        wr_addr_r <= {haddr[7:2], 2'b00};
      end
      if (bus_take && !hwrite) begin
        rd_addr_r  <= (haddr[31:8] == 24'h00_0000) ?
                      {haddr[7:2], 2'b00} : 8'hFC;
        rd_stage_r <= 2'h1;
        hreadyout  <= 1'b0;
      end else if (rd_stage_r == 2'h1) begin
        rd_stage_r <= 2'h2;
      end else if (rd_stage_r == 2'h2) begin
        rd_stage_r <= 2'h0;
        hreadyout  <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Flags, enables, vector base and event registers.
  reg  [NVEC-1:0]            flag_r;
  reg  [NVEC-1:0]            flag_nxt;
  reg  [NVEC-1:0]            en_r;
  reg  [NVEC-1:0]            src_d_r;
  reg  [31:0]                vec_base_r;
  reg  [`VISM_EVT_BITS-1:0]  evt_stat_r;
  reg  [`VISM_EVT_BITS-1:0]  evt_mask_r;
  reg  [`VISM_EVT_BITS-1:0]  evt_nxt;
  wire [NVEC-1:0]            hw_set;
  wire [NVEC-1:0]            pend;
  wire                       new_vec;

  // Edge sources flag once per rising request; persistent ones keep
  // flagging every cycle while the request is high.
  assign hw_set = (src & `VISM_PERSIST_MASK) |
                  (src & ~src_d_r & ~`VISM_PERSIST_MASK);
  assign pend   = flag_r & en_r;

  always @* begin
    flag_nxt = flag_r;
    if (wr_at(wr_pend_r, wr_addr_r, `VISM_OFF_FLAG0)) begin
      flag_nxt[31:0] = hwdata;
    end
    if (wr_at(wr_pend_r, wr_addr_r, `VISM_OFF_FLAG1)) begin
      flag_nxt[NVEC-1:32] = hwdata[`VISM_FLAG_BITS_HI-1:0];
    end
    // A hardware set in the clearing cycle wins over the clear.
    flag_nxt = flag_nxt | hw_set;
  end

  always @* begin
    evt_nxt = evt_stat_r;
    if (wr_at(wr_pend_r, wr_addr_r, `VISM_OFF_EVT_STAT)) begin
      evt_nxt = evt_stat_r & ~hwdata[`VISM_EVT_BITS-1:0];
    end
    evt_nxt[`VISM_EVT_FLAG_SET] = evt_nxt[`VISM_EVT_FLAG_SET] |
                                  (|(hw_set & ~flag_r));
    evt_nxt[`VISM_EVT_NEW_VEC]  = evt_nxt[`VISM_EVT_NEW_VEC] | new_vec;
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      flag_r     <= {NVEC{1'b0}};
      en_r       <= {NVEC{1'b0}};
      src_d_r    <= {NVEC{1'b0}};
      vec_base_r <= `VISM_RST_VEC_BASE;
      evt_stat_r <= {`VISM_EVT_BITS{1'b0}};
      evt_mask_r <= {`VISM_EVT_BITS{1'b0}};
      irq_out_r  <= 1'b0;
    end else begin
      flag_r     <= flag_nxt;
      src_d_r    <= src;
      evt_stat_r <= evt_nxt;
      irq_out_r  <= |(evt_nxt & evt_mask_r);
      if (wr_at(wr_pend_r, wr_addr_r, `VISM_OFF_EN0)) begin
        en_r[31:0] <= hwdata;
      end
      if (wr_at(wr_pend_r, wr_addr_r, `VISM_OFF_EN1)) begin
        en_r[NVEC-1:32] <= hwdata[`VISM_FLAG_BITS_HI-1:0];
      end
      if (wr_at(wr_pend_r, wr_addr_r, `VISM_OFF_VEC_BASE)) begin
        vec_base_r <= hwdata;
      end
      if (wr_at(wr_pend_r, wr_addr_r, `VISM_OFF_EVT_MASK)) begin
        evt_mask_r <= hwdata[`VISM_EVT_BITS-1:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Priority store, cleared word by word after reset.
  reg  [3:0]  clr_idx_r;
  reg         clr_busy_r;
  reg  [3:0]  scan_idx_r;
  reg  [3:0]  eval_idx_r;
  wire [31:0] bus_prio_rdata;
  wire [31:0] scan_word;
  wire        mem_we;
  wire [3:0]  mem_waddr;
  wire [31:0] mem_wdata;

  // Bus writes to the priority words are dropped during the short clearing sweep after reset.
  assign mem_we    = clr_busy_r || (wr_pend_r && wr_hit_prio);
  assign mem_waddr = clr_busy_r ? clr_idx_r : wr_widx[3:0];
  assign mem_wdata = clr_busy_r ? 32'h0000_0000 :
                     (hwdata & `VISM_PRIO_WMASK);

  always @(posedge ref_clk) begin
    if (rst) begin
      clr_idx_r  <= 4'h0;
      clr_busy_r <= 1'b1;
    end else if (clr_busy_r) begin
      clr_idx_r <= clr_idx_r + 4'h1;
      if (clr_idx_r == NPW[3:0] - 4'h1) begin
        clr_busy_r <= 1'b0;
      end
    end
  end

  vism_prio_mem #(
    .WIDTH (32),
    .DEPTH (NPW),
    .AW    (4)
  ) u_prio_mem (
    .ref_clk   (ref_clk),
    .we        (mem_we),
    .waddr     (mem_waddr),
    .wdata     (mem_wdata),
    .raddr_a   (rd_addr_r[5:2]),
    .rdata_a_r (bus_prio_rdata),
    .raddr_b   (scan_idx_r),
    .rdata_b_r (scan_word)
  );

  //////////////////////////////////////////////////////////////////////////
  // Arbitration scan: one priority word per cycle, result after each pass.
  function [4:0] slot_field;
    input [31:0] word;
    input [1:0]  slot;
    begin
      slot_field = word[slot * `VISM_SLOT_STRIDE +: 5];
    end
  endfunction

  reg        best_ok_r;
  reg  [5:0] best_vec_r;
  reg  [4:0] best_key_r;
  reg        cand_ok;
  reg  [5:0] cand_vec;
  reg  [4:0] cand_key;
  reg  [5:0] v;
  reg  [4:0] key;
  integer    k;

  // Higher priority, then higher subpriority wins; ties go to the lower
  // vector because sources are visited in ascending order.
  always @* begin
    v        = 6'h00;
    key      = 5'h00;
    cand_ok  = (eval_idx_r == 4'h0) ? 1'b0 : best_ok_r;
    cand_vec = (eval_idx_r == 4'h0) ? 6'h00 : best_vec_r;
    cand_key = (eval_idx_r == 4'h0) ? 5'h00 : best_key_r;
    for (k = 0; k < 4; k = k + 1) begin
      v   = {eval_idx_r, k[1:0]};
      key = slot_field(scan_word, k[1:0]);
      if (pend[v] && (!cand_ok || key > cand_key)) begin
        cand_ok  = 1'b1;
        cand_vec = v;
        cand_key = key;
      end
    end
  end

  assign new_vec = (eval_idx_r == NPW[3:0] - 4'h1) && cand_ok &&
                   (!irq_req_r || cand_vec != irq_vector_r);

  always @(posedge ref_clk) begin
    if (rst) begin
      scan_idx_r    <= 4'h0;
      eval_idx_r    <= 4'h0;
      best_ok_r     <= 1'b0;
      best_vec_r    <= 6'h00;
      best_key_r    <= 5'h00;
      irq_req_r     <= 1'b0;
      irq_vector_r  <= 6'h00;
      irq_prio_r    <= 3'h0;
      irq_subprio_r <= 2'h0;
      irq_handler_r <= 32'h0000_0000;
    end else begin
      scan_idx_r <= (scan_idx_r == NPW[3:0] - 4'h1) ? 4'h0 :
                    scan_idx_r + 4'h1;
      eval_idx_r <= scan_idx_r;
      best_ok_r  <= cand_ok;
      best_vec_r <= cand_vec;
      best_key_r <= cand_key;
      if (eval_idx_r == NPW[3:0] - 4'h1) begin
        irq_req_r     <= cand_ok;
        irq_vector_r  <= cand_vec;
        irq_prio_r    <= cand_key[4:2];
        irq_subprio_r <= cand_key[1:0];
        irq_handler_r <= vec_base_r +
                         ({26'h000_0000, cand_vec} * `VISM_VEC_SPACING);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read data, loaded in the last wait cycle of a read.
  reg [31:0] rd_word;

  always @* begin
    case (rd_addr_r)
      `VISM_OFF_FLAG0:    rd_word = flag_r[31:0];
      `VISM_OFF_FLAG1:    rd_word = {8'h00, flag_r[NVEC-1:32]};
      `VISM_OFF_EN0:      rd_word = en_r[31:0];
      `VISM_OFF_EN1:      rd_word = {8'h00, en_r[NVEC-1:32]};
      `VISM_OFF_VEC_BASE: rd_word = vec_base_r;
      `VISM_OFF_PENDING:  rd_word = {16'h0000, irq_req_r, 4'h0,
                                     irq_prio_r, irq_subprio_r,
                                     irq_vector_r};
      `VISM_OFF_EVT_STAT: rd_word = {30'h0000_0000, evt_stat_r};
      `VISM_OFF_EVT_MASK: rd_word = {30'h0000_0000, evt_mask_r};
      default:            rd_word = rd_hit_prio ? bus_prio_rdata :
                                    32'h0000_0000;
    endcase
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_stage_r == 2'h2) begin
      hrdata <= rd_word;
    end
  end
endmodule // vism_source_map

//--- logic/vism_source_map_regs.vh
// Register offsets, field positions, reset values and counts of the source map.
`ifndef VISM_SOURCE_MAP_REGS_VH
`define VISM_SOURCE_MAP_REGS_VH
`define VISM_NUM_VEC        7'h38
`define VISM_NUM_PRIO_WORDS 5'h0E
`define VISM_SRC_PER_WORD   3'h4
`define VISM_FLAG_BITS_HI   5'h18
`define VISM_OFF_FLAG0      8'h00
`define VISM_OFF_FLAG1      8'h04
`define VISM_OFF_EN0        8'h10
`define VISM_OFF_EN1        8'h14
`define VISM_OFF_PRIO_FIRST 8'h40
`define VISM_OFF_PRIO_LAST  8'h74
`define VISM_OFF_VEC_BASE   8'h80
`define VISM_OFF_PENDING    8'h84
`define VISM_OFF_EVT_STAT   8'h88
`define VISM_OFF_EVT_MASK   8'h8C
`define VISM_PRIO_WMASK     32'h1F1F_1F1F
`define VISM_PRIO_LSB       2
`define VISM_SUB_LSB        0
`define VISM_SLOT_STRIDE    8
`define VISM_RST_VEC_BASE   32'h0000_0000
`define VISM_VEC_SPACING    32'h0000_0020
`define VISM_PERSIST_MASK   56'hE3_FE10_0000_0000
`define VISM_EVT_FLAG_SET   0
`define VISM_EVT_NEW_VEC    1
`define VISM_EVT_BITS       2
`endif

//--- logic/vism_prio_mem.v
// Priority word store with one write port and two registered read ports.
module vism_prio_mem #(
  parameter WIDTH = 32,
  parameter DEPTH = 14,
  parameter AW    = 4
) (
  input  wire             ref_clk,
  input  wire             we,
  input  wire [AW-1:0]    waddr,
  input  wire [WIDTH-1:0] wdata,
  input  wire [AW-1:0]    raddr_a,
  output reg  [WIDTH-1:0] rdata_a_r,
  input  wire [AW-1:0]    raddr_b,
  output reg  [WIDTH-1:0] rdata_b_r
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];

  // Contents are not reset; the top clears every word after reset.
  always @(posedge ref_clk) begin
    if (we) begin
      mem_r[waddr] <= wdata;
    end
    rdata_a_r <= mem_r[raddr_a];
    rdata_b_r <= mem_r[raddr_b];
  end
endmodule // vism_prio_mem

//--- test/vism_checker.sv
// Port-level checker for the vectored interrupt source map.
module vism_checker (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        irq_req_r,
  input wire logic [5:0]  irq_vector_r,
  input wire logic [31:0] irq_handler_r,
  input wire logic        irq_out_r
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire logic rd_take = hsel && htrans[1] && hready && !hwrite;
  wire logic wr_take = hsel && htrans[1] && hready && hwrite;
  ////////////////////////////////////////////////////////////////////////////
  sequence two_waits;
    !hreadyout ##1 !hreadyout ##1 hreadyout;
  endsequence
  read_wait_a: assert property (rd_take |=> two_waits)
    else $error("read did not take two wait states");
  write_nowait_a: assert property (wr_take |=> hreadyout)
    else $error("write was stalled");
  stall_cause_a: assert property ($fell(hreadyout) |-> $past(rd_take))
    else $error("stall without a read");
  stall_max_a: assert property (!hreadyout [*2] |=> hreadyout)
    else $error("stall too long");
  resp_okay_a: assert property (!hresp)
    else $error("response not okay");
  // The bench keeps the vector base on a 2 KiB boundary.
  handler_map_a: assert property (
    irq_req_r |-> irq_handler_r[10:0] == {irq_vector_r, 5'h00})
    else $error("handler address not base plus fixed spacing");
  vector_range_a: assert property (irq_req_r |-> irq_vector_r <= 6'h37)
    else $error("vector out of range");
  reset_quiet_a: assert property (disable iff (1'b0)
    rst |=> hreadyout && !irq_req_r && !irq_out_r)
    else $error("outputs not quiet after reset");
endmodule // vism_checker

bind vism_source_map vism_checker u_chk (
  .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .irq_req_r(irq_req_r), .irq_vector_r(irq_vector_r),
  .irq_handler_r(irq_handler_r), .irq_out_r(irq_out_r));

//--- test/vism_src_model.sv
// Request sources model: one request line per non-reserved vector number.
module vism_src_model (
  input  wire logic [55:0] src,
  output logic             core_timer_req,
  output logic [1:0]       core_sw_req,
  output logic [4:0]       ext_pin_req,
  output logic [3:0]       gpio_change_req,
  output logic [2:0]       general_timer_req,
  output logic [2:0]       comparator_req,
  output logic             usb_req,
  output logic             calendar_alarm_req,
  output logic             adc_done_req,
  output logic             supply_level_detector_req,
  output logic [3:0]       logic_cell_req,
  output logic [8:0]       spi_req,
  output logic [2:0]       uart1_req
);
  // Reserved vectors have no line here, so nothing can ever drive them.
  assign core_timer_req            = src[0];
  assign core_sw_req               = src[2:1];
  assign ext_pin_req               = src[7:3];
  assign gpio_change_req           = src[11:8];
  assign general_timer_req         = src[19:17];
  assign comparator_req            = src[25:23];
  assign usb_req                   = src[29];
  assign calendar_alarm_req        = src[32];
  assign adc_done_req              = src[33];
  assign supply_level_detector_req = src[36];
  assign logic_cell_req            = src[40:37];
  assign spi_req                   = src[49:41];
  assign uart1_req                 = src[55:53];
endmodule // vism_src_model

//--- test/vism_source_map_tb_top.sv
// Self-checking bench for the vectored interrupt source map.
module vism_source_map_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [55:0] SRCS = 56'hE3_FFF3_238E_0FFF;
  localparam logic [31:0] FLAG0 = 32'h0000_0000;
  localparam logic [31:0] FLAG1 = 32'h0000_0004;
  logic        ref_clk = 1'b0;
  logic        rst     = 1'b1;
  logic        hsel    = 1'b0;
  logic        hwrite  = 1'b0;
  logic [1:0]  htrans  = 2'b00;
  logic [31:0] haddr   = 32'h0000_0000;
  logic [31:0] hwdata  = 32'h0000_0000;
  logic [55:0] src     = '0;
  logic [31:0] hrdata, hnd;
  logic [5:0]  vec;
  logic [2:0]  pri;
  logic [1:0]  sub;
  logic        hreadyout, hresp, irq_req_r, irq_out_r;
  logic        ct, usb, cal, adc, sld;
  logic [1:0]  sw;
  logic [4:0]  ext;
  logic [3:0]  gp, lc;
  logic [2:0]  gt, cmp, ua;
  logic [8:0]  spi;
  int errors = 0;
  int compares = 0;
  int cyc = 0;
  vism_src_model u_src (.src(src), .core_timer_req(ct), .core_sw_req(sw),
    .ext_pin_req(ext), .gpio_change_req(gp), .general_timer_req(gt),
    .comparator_req(cmp), .usb_req(usb), .calendar_alarm_req(cal),
    .adc_done_req(adc), .supply_level_detector_req(sld),
    .logic_cell_req(lc), .spi_req(spi), .uart1_req(ua));
  vism_source_map dut (.ref_clk(ref_clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .core_timer_req(ct),
    .core_sw_req(sw), .ext_pin_req(ext), .gpio_change_req(gp),
    .general_timer_req(gt), .comparator_req(cmp), .usb_req(usb),
    .calendar_alarm_req(cal), .adc_done_req(adc),
    .supply_level_detector_req(sld), .logic_cell_req(lc), .spi_req(spi),
    .uart1_req(ua), .irq_req_r(irq_req_r), .irq_vector_r(vec),
    .irq_prio_r(pri), .irq_subprio_r(sub), .irq_handler_r(hnd),
    .irq_out_r(irq_out_r));
  always #4 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      test_done();
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Entered just after a rising edge; the wait on hready has no own bound
  // because the cycle ceiling above ends any hang.
  task automatic bus(input logic w, input logic [31:0] a, d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    q = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input string nm, input logic [31:0] a, exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(nm, q, exp);
  endtask
  task automatic pulse(input int v);
    src[v] <= 1'b1;
    @(posedge ref_clk);
    src[v] <= 1'b0;
    @(posedge ref_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd_chk("vec_base", 32'h0000_0080, 32'h0000_0000);
    rd_chk("enable0", 32'h0000_0010, 32'h0000_0000);
    rd_chk("unmapped", 32'h0000_0100, 32'h0000_0000);
    rd_chk("gap", 32'h0000_0090, 32'h0000_0000);
    for (int n = 0; n < 14; n++) begin
      wr(32'h0000_0040 + 4 * n, 32'hFFFF_FFF0 | n);
      rd_chk("prio", 32'h0000_0040 + 4 * n, 32'h1F1F_1F10 | n);
    end
    wr(32'h0000_0000, 32'hFFFF_FFFF);
    rd_chk("reserved_flags", 32'h0000_0000, 32'hFFFF_FFFF);
    wr(32'h0000_0000, 32'h0000_0000);
    $display("test regs done");
  endtask
  task automatic t_map;
    logic [63:0] e;
    for (int v = 0; v < 56; v++) if (SRCS[v]) begin
      pulse(v);
      e = 64'h1 << v;
      rd_chk("flag0", FLAG0, e[31:0]);
      rd_chk("flag1", FLAG1, e[63:32]);
      wr(32'h0000_0000, 32'h0000_0000);
      wr(32'h0000_0004, 32'h0000_0000);
    end
    $display("test map done");
  endtask
  task automatic t_persist;
    src[36] <= 1'b1;
    src[29] <= 1'b1;
    repeat (3) @(posedge ref_clk);
    wr(32'h0000_0004, 32'h0000_0000);
    wr(32'h0000_0000, 32'h0000_0000);
    rd_chk("persist", 32'h0000_0004, 32'h0000_0010);
    rd_chk("usb_once", 32'h0000_0000, 32'h0000_0000);
    src[36] <= 1'b0;
    src[29] <= 1'b0;
    @(posedge ref_clk);
    wr(32'h0000_0004, 32'h0000_0000);
    rd_chk("persist_off", 32'h0000_0004, 32'h0000_0000);
    $display("test persist done");
  endtask
  task automatic t_arb;
    wr(32'h0000_0080, 32'h1000_0000);
    wr(32'h0000_0010, 32'h0000_0001);
    wr(32'h0000_0014, 32'h0000_0200);
    wr(32'h0000_0040, 32'h0000_000D);
    wr(32'h0000_0068, 32'h0000_1400);
    pulse(0);
    pulse(41);
    repeat (60) if (irq_req_r !== 1'b1) @(posedge ref_clk);
    repeat (40) @(posedge ref_clk);
    chk("vector", vec, 32'h0000_0029);
    chk("prio", pri, 32'h0000_0005);
    chk("handler", hnd, 32'h1000_0520);
    rd_chk("pending", 32'h0000_0084, 32'h0000_8529);
    wr(32'h0000_0004, 32'h0000_0000);
    repeat (40) @(posedge ref_clk);
    chk("vector", vec, 32'h0000_0000);
    chk("subprio", sub, 32'h0000_0001);
    chk("handler", hnd, 32'h1000_0000);
    rd_chk("pending", 32'h0000_0084, 32'h0000_8340);
    $display("test arb done");
  endtask
  task automatic t_irq;
    wr(32'h0000_0010, 32'h0000_0000);
    wr(32'h0000_0000, 32'h0000_0000);
    repeat (40) @(posedge ref_clk);
    wr(32'h0000_008C, 32'h0000_0000);
    wr(32'h0000_0088, 32'h0000_0003);
    rd_chk("status", 32'h0000_0088, 32'h0000_0000);
    pulse(1);
    repeat (2) @(posedge ref_clk);
    rd_chk("status", 32'h0000_0088, 32'h0000_0001);
    chk("masked", irq_out_r, 32'h0000_0000);
    wr(32'h0000_008C, 32'h0000_0001);
    repeat (2) @(posedge ref_clk);
    chk("irq_out", irq_out_r, 32'h0000_0001);
    wr(32'h0000_0088, 32'h0000_0001);
    repeat (2) @(posedge ref_clk);
    chk("cleared", irq_out_r, 32'h0000_0000);
    // Enabling the flagged vector publishes a new winner once, which only
    // the masked second status bit records.
    wr(32'h0000_0010, 32'h0000_0002);
    repeat (40) @(posedge ref_clk);
    rd_chk("new_vec", 32'h0000_0088, 32'h0000_0002);
    chk("mask_sel", irq_out_r, 32'h0000_0000);
    $display("test irq done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (16) @(posedge ref_clk);
    t_regs();
    t_map();
    t_persist();
    t_arb();
    t_irq();
    test_done();
  end
endmodule // vism_source_map_tb_top
